/* File: hw/scs_pkg.sv */
/*
  Shared constants, state types and gray-code helpers for the serial
  read port. Assumes clk_sys runs at 250 MHz on both ends.
*/
package scs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 250;
  localparam int SLEEP_MIN_US = 200;
  localparam int SLEEP_MAX_US = 2000;
  localparam int WAKE_MIN_US = 10;
  localparam int CS_SETUP_NS = 200;
  localparam int SCLK_HALF_NS = 500;
  localparam int SLEEP_MIN_CYC = SLEEP_MIN_US * CLK_SYS_MHZ;
  localparam int SLEEP_MAX_CYC = SLEEP_MAX_US * CLK_SYS_MHZ;
  localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_SYS_MHZ;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_SYS_MHZ) / 1000;
  localparam int CONV_OSC_CYCLES = 612;
  localparam int TMR_W = 20;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int SAMPLE_BITS = 20;
  localparam int BIT_DONE = 23;
  localparam int BIT_OVR = 22;
  localparam int BIT_OSC = 21;
  localparam int BIT_ZERO = 20;
  localparam int CNT_W = 6;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum {DEV_IDLE, DEV_READY, DEV_READ, DEV_SLEEP} scs_dev_state_e;
  typedef enum {HST_IDLE, HST_WAIT, HST_HIGH, HST_LOW, HST_PUSH, HST_SLEEP,
                HST_WAKE} scs_hst_state_e;

  function automatic logic [CNT_W-1:0] scs_bin2gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] scs_gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = '0;
    for (int i = CNT_W - 1; i >= 0; i--) begin
      b[i] = (i == CNT_W - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction

endpackage

/* File: hw/scs_link_if.sv */
/*
  Three-wire read port between converter and host: chip select, serial
  clock and serial data out. The data wire idles high through a pull-up
  whenever the converter does not drive it.
*/
`timescale 1ns/10ps
interface scs_link_if;
  logic sclk;
  logic csN;
  logic serialDataOut;
  logic serialDataOutOe;
  logic serialDataLine;

  assign serialDataLine = serialDataOutOe ? serialDataOut : 1'b1;

  modport dev (
    input sclk,
    input csN,
    output serialDataOut,
    output serialDataOutOe
  );

  modport hst (
    output sclk,
    output csN,
    input serialDataLine
  );
endinterface

/* File: hw/scs_converter.sv */
/*
  Converter end of the serial read port: conversion pacing, output word
  hold, bit presentation on the data pin and serial-clock sleep control.
  Assumes the host drives csN and sclk through the link interface; sclk
  may stop between transfers. clk_sys stands for the on-chip oscillator.
*/
// What this block does
// - Internal variant converts on own oscillator clock.
// - External variant paces conversions from serial clock.
// - In the internal variant, serial clock only reads data and triggers sleep and wake.
// - Clock held high for interval enters sleep.
// - Clock held low ten microseconds wakes device.
// - Host bursts clock at least 10 kHz.
// - Host parks serial clock low between transfers.
// - Raw words leave unaltered; no calibration inside.
// - Data pin floats whenever chip select high.
// - Pin low marks new word; high after read.
// - Twenty-four clocks per word; shift on fall.
// - Conversion during a read is discarded.
`timescale 1ns/10ps
module scs_converter
  import scs_pkg::*;
#(
  parameter bit INT_OSC = 1'b1,
  parameter int SLEEP_CYC = SLEEP_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  scs_link_if.dev link,
  input wire logic [SAMPLE_BITS-1:0] sampleIn,
  input wire logic ovrFlag,
  input wire logic oscFlag,
  output logic sleeping,
  output logic convDone,
  output logic wordLost
);

  localparam logic [TMR_W-1:0] SLEEP_LIM = TMR_W'(SLEEP_CYC);
  localparam logic [TMR_W-1:0] WAKE_LIM = TMR_W'(WAKE_MIN_CYC);
  localparam logic [9:0] CONV_LIM = 10'(CONV_OSC_CYCLES - 1);
  localparam logic [CNT_W-1:0] WORD_LEN = CNT_W'(WORD_BITS);

  // ----------------------------------------------------------------
  // Link-clock domain: falling-edge counter
  // ----------------------------------------------------------------
  // Gray code lets the system side sample the count at any moment. The
  // reset is asynchronous since sclk may be parked while rst_n is low.
  logic [CNT_W-1:0] fallBinLink_reg;
  logic [CNT_W-1:0] fallGrayLink_reg;

  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      fallBinLink_reg <= '0;
      fallGrayLink_reg <= '0;
    end else begin
      fallBinLink_reg <= fallBinLink_reg + CNT_W'(1);
      fallGrayLink_reg <= scs_bin2gray(fallBinLink_reg + CNT_W'(1));
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into clk_sys
  // ----------------------------------------------------------------
  logic sclkMeta_reg;
  logic sclkSync_reg;
  logic csNMeta_reg;
  logic csNSync_reg;
  logic [CNT_W-1:0] grayMeta_reg;
  logic [CNT_W-1:0] graySync_reg;
  logic [CNT_W-1:0] fallBin;
  logic [CNT_W-1:0] fallPrev_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclkMeta_reg <= 1'b0;
      sclkSync_reg <= 1'b0;
      csNMeta_reg <= 1'b1;
      csNSync_reg <= 1'b1;
      grayMeta_reg <= '0;
      graySync_reg <= '0;
    end else begin
      sclkMeta_reg <= link.sclk;
      sclkSync_reg <= sclkMeta_reg;
      csNMeta_reg <= link.csN;
      csNSync_reg <= csNMeta_reg;
      grayMeta_reg <= fallGrayLink_reg;
      graySync_reg <= grayMeta_reg;
    end
  end

  assign fallBin = scs_gray2bin(graySync_reg);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fallPrev_reg <= '0;
    end else begin
      fallPrev_reg <= fallBin;
    end
  end

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] highCnt_reg;
  logic [TMR_W-1:0] lowCnt_reg;
  logic sleep_reg;
  logic sleepEnter;
  logic sleepExit;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sclkSync_reg) begin
      highCnt_reg <= '0;
    end else if (highCnt_reg != SLEEP_LIM) begin
      highCnt_reg <= highCnt_reg + TMR_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || sclkSync_reg) begin
      lowCnt_reg <= '0;
    end else if (lowCnt_reg != WAKE_LIM) begin
      lowCnt_reg <= lowCnt_reg + TMR_W'(1);
    end
  end

  assign sleepEnter = !sleep_reg && (highCnt_reg == SLEEP_LIM);
  assign sleepExit = sleep_reg && (lowCnt_reg == WAKE_LIM);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_reg <= 1'b0;
    end else if (sleepEnter) begin
      sleep_reg <= 1'b1;
    end else if (sleepExit) begin
      sleep_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion pacing
  // ----------------------------------------------------------------
  // A new serial-clock fall advances the external-variant divider; at
  // most one fall lands per clk_sys cycle since sclk stays below the clk_sys rate.
  logic [9:0] convCnt_reg;
  logic convStep;
  logic convTick;

  always_comb begin
    if (INT_OSC) begin
      convStep = !sleep_reg;
    end else begin
      convStep = !sleep_reg && (fallBin != fallPrev_reg);
    end
  end

  assign convTick = convStep && (convCnt_reg == CONV_LIM);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || sleep_reg) begin
      convCnt_reg <= '0;
    end else if (convTick) begin
      convCnt_reg <= '0;
    end else if (convStep) begin
      convCnt_reg <= convCnt_reg + 10'(1);
    end
  end

  // ----------------------------------------------------------------
  // Output word and read sequencing
  // ----------------------------------------------------------------
  scs_dev_state_e state_reg;
  logic [WORD_BITS-1:0] word_reg;
  logic [CNT_W-1:0] base_reg;
  logic [CNT_W-1:0] bitNum;
  logic convDone_reg;
  logic wordLost_reg;

  assign bitNum = fallBin - base_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_reg <= '0;
    end else if (convTick && state_reg != DEV_READ) begin
      word_reg[BIT_DONE] <= 1'b0;
      word_reg[BIT_OVR] <= ovrFlag;
      word_reg[BIT_OSC] <= oscFlag;
      word_reg[BIT_ZERO] <= 1'b0;
      word_reg[SAMPLE_BITS-1:0] <= sampleIn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= DEV_IDLE;
    end else begin
      case (state_reg)
        DEV_IDLE: begin
          if (sleepEnter) begin
            state_reg <= DEV_SLEEP;
          end else if (convTick) begin
            state_reg <= DEV_READY;
          end
        end
        DEV_READY: begin
          if (sleepEnter) begin
            state_reg <= DEV_SLEEP;
          end else if (sclkSync_reg && !csNSync_reg) begin
            state_reg <= DEV_READ;
          end
        end
        DEV_READ: begin
          if (sleepEnter) begin
            state_reg <= DEV_SLEEP;
          end else if (csNSync_reg || bitNum >= WORD_LEN) begin
            state_reg <= DEV_IDLE;
          end
        end
        DEV_SLEEP: begin
          if (sleepExit) begin
            state_reg <= DEV_IDLE;
          end
        end
        default: begin
          state_reg <= DEV_IDLE;
        end
      endcase
    end
  end

  // The count base follows the fall counter until the read starts, so
  // a free-running master clock does not skew the bit index.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      base_reg <= '0;
    end else if (state_reg != DEV_READ) begin
      base_reg <= fallBin;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      convDone_reg <= 1'b0;
      wordLost_reg <= 1'b0;
    end else begin
      convDone_reg <= convTick;
      wordLost_reg <= convTick && (state_reg == DEV_READ);
    end
  end

  // ----------------------------------------------------------------
  // Data pin
  // ----------------------------------------------------------------
  // The pin lags each serial-clock fall by two to three clk_sys cycles,
  // well inside the host's sampling half period.
  logic sdo_reg;
  logic sdoOe_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sdoOe_reg <= 1'b0;
      sdo_reg <= 1'b1;
    end else begin
      sdoOe_reg <= !csNSync_reg;
      if (state_reg == DEV_READY) begin
        sdo_reg <= word_reg[BIT_DONE];
      end else if (state_reg == DEV_READ && bitNum < WORD_LEN) begin
        sdo_reg <= word_reg[5'(BIT_DONE) - bitNum[4:0]];
      end else begin
        sdo_reg <= 1'b1;
      end
    end
  end

  assign link.serialDataOut = sdo_reg;
  assign link.serialDataOutOe = sdoOe_reg;
  assign sleeping = sleep_reg;
  assign convDone = convDone_reg;
  assign wordLost = wordLost_reg;

endmodule

/* File: hw/scs_host.sv */
/*
  Host end of the serial read port, with the FIFO that buffers received
  words toward the user. Assumes the converter sits on the far side of
  the link interface; the serial clock is divided down from clk_sys.
*/
`timescale 1ns/10ps
module scs_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic doWr;
  logic doRd;

  assign inReady = (count_reg != FULL);
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWr) begin
        wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + PW'(1);
      end
      if (doRd) begin
        rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + PW'(1);
      end
      count_reg <= count_reg + (PW + 1)'(doWr) - (PW + 1)'(doRd);
    end
  end

endmodule

module scs_host
  import scs_pkg::*;
#(
  parameter int SLEEP_HOLD_CYC = SLEEP_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  scs_link_if.hst link,
  input wire logic readEnable,
  input wire logic sleepReq,
  output logic asleep,
  output logic wordValid,
  input wire logic wordReady,
  output logic [WORD_BITS-1:0] wordData
);

  localparam logic [TMR_W-1:0] HALF_LIM = TMR_W'(SCLK_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] SETUP_LIM = TMR_W'(CS_SETUP_CYC);
  localparam logic [TMR_W-1:0] HOLD_LIM = TMR_W'(SLEEP_HOLD_CYC);
  localparam logic [TMR_W-1:0] WAKE_LIM = TMR_W'(WAKE_MIN_CYC);
  localparam logic [4:0] WORD_LEN = 5'(WORD_BITS);

  // ----------------------------------------------------------------
  // Input synchroniser and buffer
  // ----------------------------------------------------------------
  logic sdoMeta_reg;
  logic sdoSync_reg;
  logic pushValid_reg;
  logic fifoInReady;
  logic [WORD_BITS-1:0] shift_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sdoMeta_reg <= 1'b1;
      sdoSync_reg <= 1'b1;
    end else begin
      sdoMeta_reg <= link.serialDataLine;
      sdoSync_reg <= sdoMeta_reg;
    end
  end

  scs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(pushValid_reg),
    .inReady(fifoInReady),
    .inData(shift_reg),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordData)
  );

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // A full buffer keeps chip select high, so the converter simply drops
  // words instead of the host losing them mid-read.
  scs_hst_state_e state_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [4:0] bitCnt_reg;
  logic sclk_reg;
  logic csN_reg;
  logic asleep_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= HST_IDLE;
      tmr_reg <= '0;
      bitCnt_reg <= '0;
      sclk_reg <= 1'b0;
      csN_reg <= 1'b1;
      asleep_reg <= 1'b0;
      pushValid_reg <= 1'b0;
      shift_reg <= '0;
    end else begin
      tmr_reg <= tmr_reg + TMR_W'(1);
      case (state_reg)
        HST_IDLE: begin
          sclk_reg <= 1'b0;
          tmr_reg <= '0;
          bitCnt_reg <= '0;
          if (sleepReq) begin
            csN_reg <= 1'b1;
            sclk_reg <= 1'b1;
            state_reg <= HST_SLEEP;
          end else if (readEnable && fifoInReady) begin
            csN_reg <= 1'b0;
            state_reg <= HST_WAIT;
          end else begin
            csN_reg <= 1'b1;
          end
        end
        HST_WAIT: begin
          if (sleepReq || !readEnable) begin
            state_reg <= HST_IDLE;
          end else if (!sdoSync_reg && tmr_reg >= SETUP_LIM) begin
            sclk_reg <= 1'b1;
            shift_reg <= {shift_reg[WORD_BITS-2:0], sdoSync_reg};
            tmr_reg <= '0;
            state_reg <= HST_HIGH;
          end else if (tmr_reg >= SETUP_LIM) begin
            tmr_reg <= SETUP_LIM;
          end
        end
        HST_HIGH: begin
          if (tmr_reg == HALF_LIM) begin
            sclk_reg <= 1'b0;
            bitCnt_reg <= bitCnt_reg + 5'(1);
            tmr_reg <= '0;
            state_reg <= HST_LOW;
          end
        end
        HST_LOW: begin
          if (tmr_reg == HALF_LIM) begin
            tmr_reg <= '0;
            if (bitCnt_reg == WORD_LEN) begin
              csN_reg <= 1'b1;
              pushValid_reg <= 1'b1;
              state_reg <= HST_PUSH;
            end else begin
              sclk_reg <= 1'b1;
              shift_reg <= {shift_reg[WORD_BITS-2:0], sdoSync_reg};
              state_reg <= HST_HIGH;
            end
          end
        end
        HST_PUSH: begin
          if (fifoInReady) begin
            pushValid_reg <= 1'b0;
            state_reg <= HST_IDLE;
          end
        end
        HST_SLEEP: begin
          if (tmr_reg == HOLD_LIM) begin
            asleep_reg <= 1'b1;
            tmr_reg <= HOLD_LIM;
          end
          if (!sleepReq) begin
            sclk_reg <= 1'b0;
            tmr_reg <= '0;
            state_reg <= HST_WAKE;
          end
        end
        HST_WAKE: begin
          if (tmr_reg == WAKE_LIM) begin
            asleep_reg <= 1'b0;
            state_reg <= HST_IDLE;
          end
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.csN = csN_reg;
  assign asleep = asleep_reg;

endmodule

/* File: dv/scs_link_properties.sv */
/*
  Assertions on the serial read port between the two ends.
  Assumes the link signals, the converter's sleeping and convDone, and the
  clk_sys and rst_n shared by both ends are wired in by name.
*/
`timescale 1ns/10ps
module scs_link_properties
  import scs_pkg::*;
#(
  parameter int SLEEP_CYC = 400
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialDataOut,
  input wire logic serialDataOutOe,
  input wire logic serialDataLine,
  input wire logic sleeping,
  input wire logic convDone
);
  logic [15:0] hiCnt;
  logic [15:0] loCnt;
  logic [15:0] gapCnt;
  logic [5:0] riseCnt;
  logic sclkDly;
  logic cleanGap;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // The hiCnt, loCnt and gapCnt counters saturate so a long sleep never wraps into a false match.
  always_ff @(posedge clk_sys) begin
    hiCnt <= (!rst_n || !sclk) ? 16'h0000 : hiCnt + {15'h0000, hiCnt != 16'hFFFF};
  end

  always_ff @(posedge clk_sys) begin
    loCnt <= (!rst_n || sclk) ? 16'h0000 : loCnt + {15'h0000, loCnt != 16'hFFFF};
  end

  always_ff @(posedge clk_sys) begin
    gapCnt <= (!rst_n || convDone) ? 16'h0001 : gapCnt + {15'h0000, gapCnt != 16'hFFFF};
  end

  // Only gaps with the port idle and awake are timed exactly.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || sleeping || !csN) begin
      cleanGap <= 1'b0;
    end else if (convDone) begin
      cleanGap <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    sclkDly <= sclk;
    if (!rst_n || csN) begin
      riseCnt <= 6'h00;
    end else if (sclk && !sclkDly) begin
      riseCnt <= riseCnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  float_deselect_a: assert property (csN [*5] |-> !serialDataOutOe)
    else $error("data pin driven while deselected");
  drive_selected_a: assert property (!csN [*6] |-> serialDataOutOe)
    else $error("data pin not driven while selected");
  ready_low_a: assert property (sclk && !sclkDly && !csN && riseCnt == 0 |-> !serialDataLine)
    else $error("first clock before word ready");
  line_high_a: assert property (!sclk && sclkDly && !csN && riseCnt == 24 |-> ##[1:12] serialDataLine)
    else $error("data line not high after word");
  frame_len_a: assert property ($rose(csN) && riseCnt != 0 |-> riseCnt == WORD_BITS)
    else $error("frame not 24 clocks");
  bit_steady_a: assert property (sclk && sclkDly && serialDataOutOe && $past(serialDataOutOe)
      |-> $stable(serialDataOut))
    else $error("data bit changed while clock high");
  burst_rate_a: assert property (!csN && sclk |-> hiCnt < SLEEP_CYC)
    else $error("clock held high during read");
  sleep_entry_a: assert property ($rose(sleeping) |-> hiCnt >= SLEEP_CYC && hiCnt <= SLEEP_CYC + 6)
    else $error("sleep entered at wrong time");
  sleep_timely_a: assert property (hiCnt == SLEEP_CYC + 8 |-> sleeping)
    else $error("sleep not entered");
  wake_exit_a: assert property ($fell(sleeping) |-> loCnt >= WAKE_MIN_CYC)
    else $error("woke too early");
  wake_timely_a: assert property (loCnt == WAKE_MIN_CYC + 8 |-> !sleeping)
    else $error("did not wake");
  asleep_quiet_a: assert property (sleeping && $past(sleeping) |-> !convDone)
    else $error("conversion while asleep");
  osc_pace_a: assert property (convDone && cleanGap |-> gapCnt == CONV_OSC_CYCLES)
    else $error("conversion spacing wrong");

  frame_c: cover property ($rose(csN) && riseCnt == 24);
  sleep_c: cover property ($rose(sleeping));
  wake_c: cover property ($fell(sleeping));
endmodule

/* File: dv/adc_serial_clock_sleep_control_tb.sv */
/*
  Self-checking bench: converter and host joined by one link, plus a second
  converter in the external-clock variant on a link that the bench drives.
  Assumes shortened sleep counts (400 and 600 cycles) on both ends.
*/
`timescale 1ns/10ps
module adc_serial_clock_sleep_control_tb;
  import scs_pkg::*;

  localparam int SLP = 400;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic readEnable = 1'b0;
  logic sleepReq = 1'b0;
  logic wordReady = 1'b0;
  logic ovrFlag = 1'b0;
  logic oscFlag = 1'b0;
  logic [SAMPLE_BITS-1:0] sampleIn = '0;
  logic sleeping, convDone, wordLost, asleep, wordValid, sleeping2, convDone2;
  logic [WORD_BITS-1:0] wordData;
  logic [WORD_BITS-1:0] rxWord = '0;
  logic [WORD_BITS-1:0] expWord = '0;
  int fail_count = 0;
  int n_compared = 0;
  int frames = 0;
  int bitCnt = 0;
  int lostCnt = 0;
  int falls2 = 0;

  // ----------------------------------------------------------------
  // Clocks and instances
  // ----------------------------------------------------------------
  scs_link_if link();
  scs_link_if link2();

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // The external variant needs a running clock as its master clock.
  initial begin
    link2.csN = 1'b1;
    link2.sclk = 1'b0;
    forever #7.5 link2.sclk = ~link2.sclk;
  end

  scs_converter #(.INT_OSC(1'b1), .SLEEP_CYC(SLP)) scs_converter_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .sampleIn(sampleIn), .ovrFlag(ovrFlag),
    .oscFlag(oscFlag), .sleeping(sleeping), .convDone(convDone), .wordLost(wordLost));
  scs_converter #(.INT_OSC(1'b0), .SLEEP_CYC(SLP)) scs_converter_inst2 (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link2), .sampleIn(sampleIn), .ovrFlag(ovrFlag),
    .oscFlag(oscFlag), .sleeping(sleeping2), .convDone(convDone2), .wordLost());
  scs_host #(.SLEEP_HOLD_CYC(600)) scs_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .readEnable(readEnable),
    .sleepReq(sleepReq), .asleep(asleep), .wordValid(wordValid), .wordReady(wordReady),
    .wordData(wordData));
  scs_link_properties #(.SLEEP_CYC(SLP)) scs_link_properties_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(link.sclk), .csN(link.csN),
    .serialDataOut(link.serialDataOut), .serialDataOutOe(link.serialDataOutOe),
    .serialDataLine(link.serialDataLine), .sleeping(sleeping), .convDone(convDone));

  // ----------------------------------------------------------------
  // Checking and wire monitor
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [WORD_BITS-1:0] mk(input logic o, input logic s,
      input logic [SAMPLE_BITS-1:0] d);
    return {1'b0, o, s, 1'b0, d};
  endfunction

  always @(posedge link.sclk) begin
    if (link.csN === 1'b0) begin
      rxWord = {rxWord[WORD_BITS-2:0], link.serialDataLine};
      bitCnt++;
    end
  end

  always @(posedge link.csN) begin
    if (bitCnt != 0) begin
      check("bits per frame", bitCnt, WORD_BITS);
      check("wire word", rxWord, expWord);
      frames++;
    end
    bitCnt = 0;
  end

  always @(posedge clk_sys) begin
    lostCnt += (wordLost === 1'b1);
  end

  always @(negedge link2.sclk) begin
    falls2++;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic pop;
    wordReady <= 1'b1;
    @(posedge clk_sys);
    wordReady <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic test_osc_pace;
    int i;
    int gap;
    for (i = 0; i < 2000 && convDone !== 1'b1; i++) @(posedge clk_sys);
    gap = 0;
    do begin
      @(posedge clk_sys);
      gap++;
    end while (convDone !== 1'b1 && gap < 2000);
    check("tick spacing", gap, CONV_OSC_CYCLES);
    check("idle clock low", link.sclk, 0);
    $display("osc_pace done");
  endtask

  task automatic test_read_hold;
    int i;
    int lost0;
    sampleIn <= 20'hA5C3E;
    ovrFlag <= 1'b1;
    expWord = mk(1'b1, 1'b0, 20'hA5C3E);
    repeat (700) @(posedge clk_sys);
    readEnable <= 1'b1;
    for (i = 0; i < 8000 && bitCnt == 0; i++) @(posedge clk_sys);
    repeat (10) @(posedge clk_sys);
    lost0 = lostCnt;
    sampleIn <= 20'h3C5A1;
    ovrFlag <= 1'b0;
    oscFlag <= 1'b1;
    for (i = 0; i < 8000 && wordValid !== 1'b1; i++) @(posedge clk_sys);
    check("held word", wordData, mk(1'b1, 1'b0, 20'hA5C3E));
    check("word lost seen", lostCnt > lost0, 1);
    expWord = mk(1'b0, 1'b1, 20'h3C5A1);
    pop();
    $display("read_hold done");
  endtask

  // The user side stalls here, so the buffer must fill and refuse reads.
  task automatic test_fill_drain;
    int i;
    int lowCnt;
    lowCnt = 0;
    for (i = 0; i < 30000 && frames < 5; i++) @(posedge clk_sys);
    for (i = 0; i < 2000; i++) begin
      @(posedge clk_sys);
      lowCnt += (link.csN !== 1'b1);
    end
    check("reads while full", lowCnt, 0);
    readEnable <= 1'b0;
    for (i = 0; i < 4; i++) begin
      check("buffered", wordValid, 1);
      check("drained word", wordData, expWord);
      pop();
    end
    check("empty after drain", wordValid, 0);
    $display("fill_drain done");
  endtask

  task automatic test_sleep_wake;
    int i;
    int convs;
    convs = 0;
    sleepReq <= 1'b1;
    for (i = 0; i < 1500 && asleep !== 1'b1; i++) @(posedge clk_sys);
    check("device asleep", sleeping, 1);
    check("clock held high", link.sclk, 1);
    for (i = 0; i < 1500; i++) begin
      @(posedge clk_sys);
      convs += (convDone === 1'b1);
    end
    check("conversions asleep", convs, 0);
    sleepReq <= 1'b0;
    for (i = 0; i < 4000 && sleeping !== 1'b0; i++) @(posedge clk_sys);
    check("wake delay", i >= WAKE_MIN_CYC && i < 4000, 1);
    for (i = 0; i < 200 && asleep !== 1'b0; i++) @(posedge clk_sys);
    check("host awake", asleep, 0);
    check("clock parked low", link.sclk, 0);
    for (i = 0; i < 700 && convDone !== 1'b1; i++) @(posedge clk_sys);
    check("conversions resume", convDone, 1);
    $display("sleep_wake done");
  endtask

  task automatic wait_conv2(inout logic hiz);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      hiz &= (link2.serialDataOutOe === 1'b0);
      if (convDone2 === 1'b1) break;
    end
  endtask

  task automatic test_ext_clock;
    int f0;
    logic hiz;
    hiz = 1'b1;
    wait_conv2(hiz);
    f0 = falls2;
    repeat (3) wait_conv2(hiz);
    check("ext pacing", (falls2 - f0) inside {[1835:1837]}, 1);
    check("float while deselected", hiz, 1);
    check("ext stays awake", sleeping2, 0);
    $display("ext_clock done");
  endtask

  initial begin
    #300000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_osc_pace();
    test_read_hold();
    test_fill_drain();
    test_sleep_wake();
    test_ext_clock();
    finish_test();
  end
endmodule
